// ===== verilog/gpc_pkg.sv
// ****************************************************************
// Shared constants and types of the general purpose clock block
// ****************************************************************
package gpc_pkg;

	// ****************************************************************
	// Block dimensions
	// ****************************************************************
	localparam int NGEN      = 3;   // Identical generators
	localparam int NSRC      = 7;   // External source inputs, codes 1..7
	localparam int FRAC_BITS = 10;  // Fraction weight is 1/1024

	// ****************************************************************
	// Register byte addresses
	// ****************************************************************
	localparam logic [31:0] GP0_CTL_ADR = 32'h7e10_1070;
	localparam logic [31:0] GP0_DIV_ADR = 32'h7e10_1074;
	localparam logic [31:0] GP1_CTL_ADR = 32'h7e10_1078;
	localparam logic [31:0] GP1_DIV_ADR = 32'h7e10_107c;
	localparam logic [31:0] GP2_CTL_ADR = 32'h7e10_1080;
	localparam logic [31:0] GP2_DIV_ADR = 32'h7e10_1084;

	// ****************************************************************
	// Field positions, key and reset values
	// ****************************************************************
	localparam int         KEY_LSB   = 24;
	localparam logic [7:0] WRITE_KEY = 8'h5a;
	localparam int         ORDER_LSB = 9;
	localparam int         FLIP_BIT  = 8;
	localparam int         BUSY_BIT  = 7;
	localparam int         KILL_BIT  = 5;
	localparam int         GENERATOR_ENABLE_BIT  = 4;
	localparam int         SRC_LSB   = 0;
	localparam int         DIVISOR_INTEGER_LSB  = 12;
	localparam int         DIVISOR_FRACTION_LSB  = 0;
	localparam logic [3:0] SRC_LAST  = 4'h7;  // Codes above read as ground

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic [1:0] order;
		logic       flip;
		logic       kill;
		logic       generator_enable;
		logic [3:0] src;
	} gpc_ctl_s;

	typedef struct packed {
		logic [11:0] divisor_integer;
		logic [11:0] divisor_fraction;
	} gpc_div_s;

	localparam gpc_ctl_s CTL_RST = '{order: 2'h0, flip: 1'b0, kill: 1'b0, generator_enable: 1'b0, src: 4'h0};
	localparam gpc_div_s DIV_RST = '{divisor_integer: 12'h000, divisor_fraction: 12'h000};

	typedef enum logic [2:0] {
		GPC_IDLE = 3'b001,
		GPC_HIGH = 3'b010,
		GPC_LOW  = 3'b100
	} gpc_state_e;

endpackage : gpc_pkg

// ===== verilog/gpc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Three-stage sampler for the external source clocks
// ****************************************************************
module gpc_sync
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Raw source pins
	input  wire logic [NSRC-1:0] async_i,
	// Filtered levels
	output logic      [NSRC-1:0] level_o
);

	logic [NSRC-1:0] s1_r;
	logic [NSRC-1:0] s2_r;
	logic [NSRC-1:0] s3_r;
	logic [NSRC-1:0] level_r;

	// Sampling chain, first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Level moves only when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_r <= '0;
		end else begin
			level_r <= (s2_r & s3_r) | (level_r & (s2_r | s3_r));
		end
	end

	assign level_o = level_r;

endmodule : gpc_sync
`default_nettype wire

// ===== verilog/gpc_noise_shaping_order.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Noise shaper: cascaded first order accumulators
// ****************************************************************
module gpc_noise_shaping_order
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Control
	input  wire logic              clear_i,
	input  wire logic              step_i,
	input  wire logic [1:0]        order_i,
	input  wire logic [11:0]       divisor_fraction_i,
	// Period correction for the next output cycle
	output logic signed [4:0]      offset_o
);

	logic [FRAC_BITS-1:0] acc1_r;
	logic [FRAC_BITS-1:0] acc2_r;
	logic [FRAC_BITS-1:0] acc3_r;
	logic                 c2_d_r;
	logic                 c3_d_r;
	logic                 c3_dd_r;
	logic signed [4:0]    offset_r;
	logic [12:0]          sum1;
	logic [10:0]          sum2;
	logic [10:0]          sum3;
	logic signed [4:0]    offset_nxt;

	// Stage sums; a wide fraction may carry more than once
	always_comb begin
		sum1 = 13'({3'b000, acc1_r}) + 13'({1'b0, divisor_fraction_i});
		sum2 = 11'({1'b0, acc2_r}) + 11'({1'b0, sum1[FRAC_BITS-1:0]});
		sum3 = 11'({1'b0, acc3_r}) + 11'({1'b0, sum2[FRAC_BITS-1:0]});
		case (order_i)
			2'd0: offset_nxt = 5'sd0;
			2'd1: offset_nxt = $signed({2'b00, sum1[12:10]});
			2'd2: offset_nxt = $signed({2'b00, sum1[12:10]})
				+ $signed({4'b0000, sum2[10]}) - $signed({4'b0000, c2_d_r});
			default: offset_nxt = $signed({2'b00, sum1[12:10]})
				+ $signed({4'b0000, sum2[10]}) - $signed({4'b0000, c2_d_r})
				+ $signed({4'b0000, sum3[10]}) - $signed({3'b000, c3_d_r, 1'b0})
				+ $signed({4'b0000, c3_dd_r});
		endcase
	end

	// Accumulators advance once per output cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			acc1_r   <= '0;
			acc2_r   <= '0;
			acc3_r   <= '0;
			c2_d_r   <= 1'b0;
			c3_d_r   <= 1'b0;
			c3_dd_r  <= 1'b0;
			offset_r <= 5'sd0;
		end else if (step_i) begin
			acc1_r   <= sum1[FRAC_BITS-1:0];
			acc2_r   <= sum2[FRAC_BITS-1:0];
			acc3_r   <= sum3[FRAC_BITS-1:0];
			c2_d_r   <= sum2[10];
			c3_d_r   <= sum3[10];
			c3_dd_r  <= c3_d_r;
			offset_r <= offset_nxt;
		end
	end

	// Integer mode ignores any correction left over from an earlier shaped run
	assign offset_o = (order_i == 2'd0) ? 5'sd0 : offset_r;

endmodule : gpc_noise_shaping_order
`default_nettype wire

// ===== verilog/gpc_top.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Shaping order 0 is integer division, 1 one stage, 2 two stages, 3 three stages.
// - Bit 8 inverts the output, each toggle while idle making an edge, for test use only.
// - Read-only bit 7 is high whenever the generator runs and makes output cycles.
// - Writing 1 to bit 5 stops and resets the generator at once and holds it there until 0 is written.
// - Bit 4 starts and stops the output cleanly, finishing the cycle in progress.
// - After enable clears, busy stays high until the final cycle ends, then drops.
// - Source codes pick ground, oscillator, two test inputs, three taps, aux, ground.
// - Divisor bits 23-12 hold the integer part, whose minimum depends on the order.
// - Divisor bits 11-0 hold the fraction used by the shaped modes.
// - Fractional modes drop source pulses so the mean divisor is integer plus fraction/1024.
module gpc_top
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Wishbone slave
	input  wire logic [31:0]     adr_i,
	input  wire logic [31:0]     dat_i,
	input  wire logic [3:0]      sel_i,
	input  wire logic            we_i,
	input  wire logic            cyc_i,
	input  wire logic            stb_i,
	output logic      [31:0]     dat_o,
	output logic                 ack_o,
	// Source clock pins
	input  wire logic            osc_i,
	input  wire logic            test_source_a_i,
	input  wire logic            test_source_b_i,
	input  wire logic            pll_first_peripheral_tap_i,
	input  wire logic            pll_second_peripheral_tap_i,
	input  wire logic            pll_third_peripheral_tap_i,
	input  wire logic            display_aux_i,
	// Generated clocks to the pins
	output logic      [NGEN-1:0] gp_clk_o
);

	// ****************************************************************
	// Register storage and bus state
	// ****************************************************************
	localparam logic [31:0] CTL_ADR [NGEN] = '{GP0_CTL_ADR, GP1_CTL_ADR, GP2_CTL_ADR};
	localparam logic [31:0] DIV_ADR [NGEN] = '{GP0_DIV_ADR, GP1_DIV_ADR, GP2_DIV_ADR};

	gpc_ctl_s        ctl_r   [NGEN];
	gpc_div_s        div_r   [NGEN];
	gpc_state_e      state_r [NGEN];
	logic [12:0]     cnt_r   [NGEN];
	logic [12:0]     per_r   [NGEN];
	logic [12:0]     per_nxt [NGEN];
	logic signed [4:0] offset [NGEN];
	logic [NGEN-1:0] busy;
	logic [NGEN-1:0] ev;
	logic [NGEN-1:0] step;
	logic [NGEN-1:0] lvl_sel;
	logic [NGEN-1:0] lvl_prev_r;
	logic [NGEN-1:0] out_r;
	logic [NSRC-1:0] src_lvl;
	logic            ack_r;
	logic [31:0]     dat_r;
	logic [31:0]     rd_val;
	logic            req;
	logic            key_ok;
	logic            wr_ok;

	// New request seen while no answer is pending
	assign req    = cyc_i && stb_i && !ack_r;
	assign key_ok = (dat_i[KEY_LSB +: 8] == WRITE_KEY);
	// Partial writes are dropped: the key lane must be present
	assign wr_ok  = req && we_i && (sel_i == 4'hf) && key_ok;

	// ****************************************************************
	// Source sampling
	// ****************************************************************
	gpc_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({display_aux_i, pll_third_peripheral_tap_i,
			pll_second_peripheral_tap_i, pll_first_peripheral_tap_i,
			test_source_b_i, test_source_a_i, osc_i}),
		.level_o (src_lvl)
	);

	// ****************************************************************
	// Bus answer: one wait state, then ack for one cycle
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Read data captured with the request; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req && !we_i) begin
			dat_r <= rd_val;
		end
	end

	// Read mux; key byte and unused bits read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		for (int i = 0; i < NGEN; i++) begin
			if (adr_i == CTL_ADR[i]) begin
				rd_val[ORDER_LSB +: 2] = ctl_r[i].order;
				rd_val[FLIP_BIT]       = ctl_r[i].flip;
				rd_val[BUSY_BIT]       = busy[i];
				rd_val[KILL_BIT]       = ctl_r[i].kill;
				rd_val[GENERATOR_ENABLE_BIT]       = ctl_r[i].generator_enable;
				rd_val[SRC_LSB +: 4]   = ctl_r[i].src;
			end
			if (adr_i == DIV_ADR[i]) begin
				rd_val[DIVISOR_INTEGER_LSB +: 12] = div_r[i].divisor_integer;
				rd_val[DIVISOR_FRACTION_LSB +: 12] = div_r[i].divisor_fraction;
			end
		end
	end

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ****************************************************************
	// Per generator logic
	// ****************************************************************
	for (genvar g = 0; g < NGEN; g++) begin : gen_ch

		// Control and divisor registers, keyed writes only
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				ctl_r[g] <= CTL_RST;
				div_r[g] <= DIV_RST;
			end else if (wr_ok) begin
				if (adr_i == CTL_ADR[g]) begin
					ctl_r[g].order <= dat_i[ORDER_LSB +: 2];
					ctl_r[g].flip  <= dat_i[FLIP_BIT];
					ctl_r[g].kill  <= dat_i[KILL_BIT];
					ctl_r[g].generator_enable  <= dat_i[GENERATOR_ENABLE_BIT];
					ctl_r[g].src   <= dat_i[SRC_LSB +: 4];
				end
				if (adr_i == DIV_ADR[g]) begin
					div_r[g].divisor_integer <= dat_i[DIVISOR_INTEGER_LSB +: 12];
					div_r[g].divisor_fraction <= dat_i[DIVISOR_FRACTION_LSB +: 12];
				end
			end
		end

		// Source pick; ground codes hold the level low, so only a switch from a high source gives an edge
		always_comb begin
			if (ctl_r[g].src != 4'h0 && ctl_r[g].src <= SRC_LAST) begin
				lvl_sel[g] = src_lvl[3'(ctl_r[g].src - 4'h1)];
			end else begin
				lvl_sel[g] = 1'b0;
			end
		end

		// Previous level of the chosen source, for edge events
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lvl_prev_r[g] <= 1'b0;
			end else begin
				lvl_prev_r[g] <= lvl_sel[g];
			end
		end

		// Both source edges count, so each output half lasts divisor source half periods
		assign ev[g]   = lvl_sel[g] ^ lvl_prev_r[g];
		assign busy[g] = (state_r[g] != GPC_IDLE);

		// Shaper steps when a new output cycle begins
		assign step[g] = ev[g] && ctl_r[g].generator_enable && !ctl_r[g].kill
			&& ((state_r[g] == GPC_IDLE)
			|| (state_r[g] == GPC_LOW && cnt_r[g] == 13'h0000));

		gpc_noise_shaping_order u_noise_shaping_order (
			.clk_i    (clk_i),
			.rst_i    (rst_i),
			.clear_i  (ctl_r[g].kill),
			.step_i   (step[g]),
			.order_i  (ctl_r[g].order),
			.divisor_fraction_i   (div_r[g].divisor_fraction),
			.offset_o (offset[g])
		);

		// Next period, never below one source period
		always_comb begin
			logic signed [14:0] per_s;
			per_s = $signed({3'b000, div_r[g].divisor_integer}) + $signed({{10{offset[g][4]}}, offset[g]});
			if (per_s < 15'sd1) begin
				per_nxt[g] = 13'h0001;
			end else begin
				per_nxt[g] = per_s[12:0];
			end
		end

		// Cycle engine; kill overrides everything
		always_ff @(posedge clk_i) begin
			if (rst_i || ctl_r[g].kill) begin
				state_r[g] <= GPC_IDLE;
				cnt_r[g]   <= 13'h0000;
				per_r[g]   <= 13'h0001;
			end else if (ev[g]) begin
				case (state_r[g])
					GPC_IDLE: begin
						if (ctl_r[g].generator_enable) begin
							state_r[g] <= GPC_HIGH;
							per_r[g]   <= per_nxt[g];
							cnt_r[g]   <= per_nxt[g] - 13'h0001;
						end
					end
					GPC_HIGH: begin
						if (cnt_r[g] == 13'h0000) begin
							state_r[g] <= GPC_LOW;
							cnt_r[g]   <= per_r[g] - 13'h0001;
						end else begin
							cnt_r[g] <= cnt_r[g] - 13'h0001;
						end
					end
					GPC_LOW: begin
						if (cnt_r[g] != 13'h0000) begin
							cnt_r[g] <= cnt_r[g] - 13'h0001;
						end else if (ctl_r[g].generator_enable) begin
							state_r[g] <= GPC_HIGH;
							per_r[g]   <= per_nxt[g];
							cnt_r[g]   <= per_nxt[g] - 13'h0001;
						end else begin
							state_r[g] <= GPC_IDLE;
						end
					end
					default: begin
						state_r[g] <= GPC_IDLE;
					end
				endcase
			end
		end

		// Output flop; inversion applies even when stopped
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				out_r[g] <= 1'b0;
			end else begin
				out_r[g] <= ctl_r[g].flip ^ (state_r[g] == GPC_HIGH);
			end
		end

		// ****************************************************************
		// Checks
		// ****************************************************************
		busy_drop_a: assert property ($fell(busy[g]) |-> $past(ctl_r[g].kill)
			|| ($past(!ctl_r[g].generator_enable) && $past(state_r[g] == GPC_LOW)))
			else $error("busy fell outside a finished cycle");
		start_run_a: assert property (ev[g] && state_r[g] == GPC_IDLE
			&& ctl_r[g].generator_enable && !ctl_r[g].kill |=> busy[g] ##1 out_r[g] != ctl_r[g].flip)
			else $error("enabled generator did not start");
		kill_stop_a: assert property (ctl_r[g].kill |=> !busy[g] ##1 out_r[g] == ctl_r[g].flip)
			else $error("kill did not stop generator");
		flip_edge_a: assert property ($changed(ctl_r[g].flip) && !busy[g]
			&& $past(!busy[g]) |=> $changed(out_r[g]))
			else $error("inversion change made no edge");
		int_period_a: assert property (step[g] && ctl_r[g].order == 2'd0
			&& div_r[g].divisor_integer != 12'h000 |=> per_r[g] == {1'b0, div_r[g].divisor_integer})
			else $error("integer mode period differs from divisor");
		shape_range_a: assert property (step[g] && div_r[g].divisor_integer > 12'h004
			|=> per_r[g] + 13'h0003 >= {1'b0, $past(div_r[g].divisor_integer)}
			&& per_r[g] <= {1'b0, $past(div_r[g].divisor_integer)} + 13'h0008)
			else $error("shaped period out of range");
		ground_src_a: assert property (ctl_r[g].src > SRC_LAST
			&& $past(ctl_r[g].src > SRC_LAST) ##0 $past(ctl_r[g].src > SRC_LAST, 2)
			|-> !ev[g])
			else $error("ground source produced an edge");
		half_len_a: assert property (busy[g] && ev[g] && cnt_r[g] != 13'h0000 && !ctl_r[g].kill
			|=> $stable(state_r[g]) && cnt_r[g] == $past(cnt_r[g]) - 13'h0001)
			else $error("cycle ended before its count ran out");
		key_guard_a: assert property (req && we_i && !key_ok
			|=> $stable(ctl_r[g]) && $stable(div_r[g]))
			else $error("write without key changed a field");
		reset_zero_a: assert property (@(posedge clk_i) disable iff (1'b0)
			rst_i |=> ctl_r[g] == CTL_RST && div_r[g] == DIV_RST && !out_r[g])
			else $error("fields not zero after reset");
	end

	assign gp_clk_o = out_r;

	// Bus answer timing
	ack_pulse_a: assert property (req |=> ack_o ##1 !ack_o)
		else $error("ack not a single cycle after request");

endmodule : gpc_top
`default_nettype wire

// ===== tb/gpc_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********************
// Source clock model
// ********************
module gpc_src_model
	import gpc_pkg::*;
(
	// Source clocks, code k+1 on bit k
	output wire logic [NSRC-1:0] src_o
);
	// Free-running clocks, half period 4*(k+2) ns
	// Offset by 1 ns so no edge meets a bench clock edge
	for (genvar k = 0; k < NSRC; k++) begin : g_src
		logic lvl_r;
		initial begin
			lvl_r = 1'b0;
			#1;
			forever #(4 * (k + 2)) lvl_r = ~lvl_r;
		end
		assign src_o[k] = lvl_r;
	end
endmodule : gpc_src_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ********************
// Clock generator bench
// ********************
module testbench
	import gpc_pkg::*;
;
	logic            clk_i;
	logic            rst_i;
	logic [31:0]     adr_i;
	logic [31:0]     dat_i;
	logic [3:0]      sel_i;
	logic            we_i;
	logic            cyc_i;
	logic            stb_i;
	logic [31:0]     dat_o;
	logic            ack_o;
	wire  [NSRC-1:0] src;
	logic [NGEN-1:0] gp_clk_o;
	int              fail_count;
	int              n_compared;
	int              g;
	int              c;
	int              run;
	int              hi_w;
	logic [31:0]     q;
	logic [31:0]     v;
	logic [11:0]     dv;
	logic [11:0]     df;
	logic [7:0]      key;

	// Device and source clocks
	gpc_top i_gpc_top (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.osc_i(src[0]), .test_source_a_i(src[1]), .test_source_b_i(src[2]),
		.pll_first_peripheral_tap_i(src[3]), .pll_second_peripheral_tap_i(src[4]),
		.pll_third_peripheral_tap_i(src[5]), .display_aux_i(src[6]), .gp_clk_o(gp_clk_o)
	);
	gpc_src_model i_gpc_src_model (.src_o(src));

	// 250 MHz clock
	initial clk_i = 1'b0;
	always #2 clk_i = ~clk_i;

	// Width of the last completed high phase of the watched generator
	always @(posedge clk_i) begin
		if (gp_clk_o[g] === 1'b1) run <= run + 1;
		else begin
			if (run != 0) hi_w <= run;
			run <= 0;
		end
	end

	// ********************
	// Checks and expectations
	// ********************
	task automatic stop_test();
		if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Reports the count itself when within tolerance, else the target
	function automatic int near(input int cnt, input int e, input int t);
		return (cnt >= e - t && cnt <= e + t) ? cnt : e;
	endfunction : near

	function automatic logic [31:0] cw(input logic [3:0] s, input logic e, k, f,
			input logic [1:0] o);
		return {21'h0, o, f, 2'b00, k, e, s};
	endfunction : cw

	function automatic logic [31:0] ctr(input int n);
		return GP0_CTL_ADR + 32'(8 * n);
	endfunction : ctr

	function automatic logic [31:0] dvr(input int n);
		return GP0_DIV_ADR + 32'(8 * n);
	endfunction : dvr

	// Clock count of n output periods, each divisor oscillator periods (4 clk each), fraction only when shaped
	function automatic int frac_exp(input int n, input int i, input int f, input int o);
		return n * 4 * (i * 1024 + (o != 0 ? f : 0)) / 1024;
	endfunction : frac_exp

	// ********************
	// Bus and generator tasks
	// ********************
	// Classic cycle held until ack; no fixed latency assumed
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) check(32'h0, 32'h1);
	endtask : wb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		wb(1'b1, a, {WRITE_KEY, d[23:0]});
	endtask : wr

	task automatic rd(input logic [31:0] a);
		wb(1'b0, a, 32'h0);
	endtask : rd

	task automatic start(input logic [3:0] s, input logic [1:0] o);
		wr(ctr(g), cw(s, 1'b0, 1'b0, 1'b0, o));
		wr(ctr(g), cw(s, 1'b1, 1'b0, 1'b0, o));
	endtask : start

	// Stop request, then poll busy; output must rest low once idle
	task automatic halt(input logic [3:0] s, input logic [1:0] o);
		int n;
		n = 0;
		wr(ctr(g), cw(s, 1'b0, 1'b0, 1'b0, o));
		do begin
			rd(ctr(g));
			n++;
		end while (q[BUSY_BIT] !== 1'b0 && n < 100);
		check({31'h0, q[BUSY_BIT]}, 32'h0);
		check({31'h0, gp_clk_o[g]}, 32'h0);
	endtask : halt

	// Counts clk cycles across n output periods, from the first rise
	task automatic meas(input int n, output int cyc);
		int k;
		int t;
		logic p;
		k = -1;
		t = 0;
		cyc = 0;
		p = 1'b1;
		while (k < n && t < 4000) begin
			@(posedge clk_i);
			t++;
			if (k >= 0) cyc++;
			if (gp_clk_o[g] === 1'b1 && p === 1'b0) k++;
			p = gp_clk_o[g];
		end
		if (k < n) check(32'h0, 32'h1);
	endtask : meas

	// Hang guard, well beyond the expected run
	initial begin
		#200_000;
		fail_count++;
		stop_test();
	end

	// ********************
	// Main sequence
	// ********************
	initial begin
		void'($urandom(32'had95));
		g <= 0;
		run <= 0;
		hi_w <= 0;
		rst_i <= 1'b1;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		adr_i <= 32'h0;
		dat_i <= 32'h0;
		sel_i <= 4'hf;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values, and an unmapped word
		for (int a = 0; a < 6; a++) begin
			rd(GP0_CTL_ADR + 32'(4 * a));
			check(q, 32'h0);
		end
		rd(GP2_DIV_ADR + 32'h0000_0004);
		check(q, 32'h0);
		check({29'h0, gp_clk_o}, 32'h0);
		// Random fields, then a write under a wrong key
		for (int i = 0; i < 6; i++) begin
			g = $urandom_range(NGEN - 1);
			v = $urandom & 32'h00ff_fb0f;
			wr(ctr(g), v);
			rd(ctr(g));
			check(q, v & 32'h0000_070f);
			key = 8'($urandom);
			if (key == WRITE_KEY) key ^= 8'h01;
			wb(1'b1, ctr(g), {key, 24'h00_0135});
			wb(1'b1, dvr(g), {key, 24'h12_3456});
			rd(ctr(g));
			check(q, v & 32'h0000_070f);
			rd(dvr(g));
			check(q, 32'h0);
			wr(ctr(g), 32'h0);
		end
		// Each source code in integer mode, then a clean stop
		for (int s = 1; s <= NSRC; s++) begin
			g = $urandom_range(NGEN - 1);
			dv = 12'($urandom_range(4, 2));
			wr(dvr(g), {8'h0, dv, 12'h0});
			start(4'(s), 2'd0);
			meas(4, c);
			check(32'(c), 32'(near(c, 8 * (s + 1) * dv, 2)));
			rd(ctr(g));
			check(q, cw(4'(s), 1'b1, 1'b0, 1'b0, 2'd0) | 32'h0000_0080);
			halt(4'(s), 2'd0);
			check(32'(hi_w), 32'(near(hi_w, (s + 1) * dv, 1)));
		end
		// Ground codes never start the generator
		for (int s = 0; s < 16; s++) begin
			if (s == 0 || s >= 8) begin
				start(4'(s), 2'd0);
				repeat (40) @(posedge clk_i);
				check({31'h0, gp_clk_o[g]}, 32'h0);
				rd(ctr(g));
				check(q, cw(4'(s), 1'b1, 1'b0, 1'b0, 2'd0));
				wr(ctr(g), 32'h0);
			end
		end
		// Every shaping order against the mean period
		for (int o = 0; o < 4; o++) begin
			g = $urandom_range(NGEN - 1);
			dv = 12'($urandom_range(8, 6));
			df = 12'($urandom_range(1023, 512));
			wr(dvr(g), {8'h0, dv, df});
			rd(dvr(g));
			check(q, {8'h0, dv, df});
			start(4'h1, 2'(o));
			meas(32, c);
			check(32'(c), 32'(near(c, frac_exp(32, dv, df, o), 8 * o + 4)));
			halt(4'h1, 2'(o));
		end
		// Kill in mid high phase, held until released
		wr(dvr(g), {8'h0, 12'h008, 12'h0});
		start(4'h1, 2'd0);
		meas(1, c);
		wr(ctr(g), cw(4'h1, 1'b1, 1'b1, 1'b0, 2'd0));
		repeat (2) @(posedge clk_i);
		check({31'h0, gp_clk_o[g]}, 32'h0);
		repeat (40) @(posedge clk_i);
		rd(ctr(g));
		check(q, cw(4'h1, 1'b1, 1'b1, 1'b0, 2'd0));
		check({31'h0, gp_clk_o[g]}, 32'h0);
		halt(4'h1, 2'd0);
		// Inversion while idle makes an edge each way
		wr(ctr(g), cw(4'h0, 1'b0, 1'b0, 1'b1, 2'd0));
		repeat (2) @(posedge clk_i);
		check({31'h0, gp_clk_o[g]}, 32'h1);
		wr(ctr(g), 32'h0);
		repeat (2) @(posedge clk_i);
		check({31'h0, gp_clk_o[g]}, 32'h0);
		stop_test();
	end
endmodule : testbench
`default_nettype wire
